// File: rtl/arcc_pkg.sv
// Purpose: constants shared by the converter result correction register block
// Assumes: 32-bit classic Wishbone bus, word index times four gives the byte address
// Notes: gain factor is 1.11 unsigned fixed point, offset term is 12-bit two's complement
package arcc_pkg;
  // register word indices (byte address is index times four)
  localparam logic [5:0] ARCC_IDX_GAIN = 6'h24;
  localparam logic [5:0] ARCC_IDX_OFFS = 6'h26;
  localparam logic [5:0] ARCC_IDX_TRIM = 6'h28;
  localparam logic [5:0] ARCC_IDX_DBG = 6'h2A;
  localparam logic [5:0] ARCC_IDX_WINUP = 6'h2C;
  localparam logic [5:0] ARCC_IDX_CTRL = 6'h2E;
  localparam logic [5:0] ARCC_IDX_STAT = 6'h30;

  // field widths and positions
  localparam int ARCC_RES_W = 12;
  localparam int ARCC_WIN_W = 16;
  localparam int ARCC_TRIM_W = 11;
  localparam int ARCC_GAIN_FRAC = 11;
  localparam int ARCC_CTRL_EN_BIT = 0;
  localparam int ARCC_CTRL_CORR_BIT = 1;
  localparam int ARCC_CTRL_WIN_BIT = 2;
  localparam int ARCC_DBG_RUN_BIT = 0;
  localparam int ARCC_STAT_ABOVE_BIT = 16;
  localparam int ARCC_STAT_RUN_BIT = 17;

  // reset values
  localparam logic [11:0] ARCC_GAIN_RST = 12'h000;
  localparam logic [11:0] ARCC_OFFS_RST = 12'h000;
  localparam logic [10:0] ARCC_TRIM_RST = 11'h000;
  localparam logic ARCC_DBG_RUN_RST = 1'b0;
  localparam logic [15:0] ARCC_WINUP_RST = 16'h0000;
  localparam logic [2:0] ARCC_CTRL_RST = 3'h0;

  // datapath constants
  localparam logic [11:0] ARCC_GAIN_ONE = 12'h800;
  localparam logic [11:0] ARCC_RES_MAX = 12'hFFF;

  // merge write data into an old word under the byte lane selects
  function automatic logic [31:0] arcc_bytewrite(input logic [31:0] old_w,
                                                 input logic [31:0] new_w,
                                                 input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction
endpackage

// File: rtl/arcc_correct.sv
// Purpose: gain and offset correction of one conversion result
// Assumes: one result per valid_i pulse, output registered one cycle later
// Notes: result is saturated to the 12-bit range after correction
`timescale 1ns/1ns
module arcc_correct (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw result in
  input wire logic valid_i,
  input wire logic [arcc_pkg::ARCC_RES_W-1:0] raw_i,
  // correction settings
  input wire logic corr_en_i,
  input wire logic [11:0] gain_i,
  input wire logic [11:0] offset_i,
  // corrected result out
  output logic valid_o,
  output logic [arcc_pkg::ARCC_RES_W-1:0] result_o
);
  import arcc_pkg::*;

  logic signed [13:0] diff;
  logic signed [26:0] prod;
  logic signed [15:0] scaled;
  logic [11:0] clamped;
  logic [11:0] result_d;
  logic valid_q;
  logic [11:0] result_q;

  // subtract signed offset, then scale by the 1.11 gain factor
  assign diff = $signed({2'b00, raw_i}) - $signed({{2{offset_i[11]}}, offset_i});
  assign prod = diff * $signed({1'b0, gain_i});
  assign scaled = 16'(prod >>> ARCC_GAIN_FRAC);
  assign clamped = scaled[15] ? 12'h000 :
                   (scaled > $signed({4'h0, ARCC_RES_MAX})) ? ARCC_RES_MAX : scaled[11:0];
  // bypass when compensation is off
  assign result_d = corr_en_i ? clamped : raw_i;

  // output register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      result_q <= 12'h000;
    end else begin
      valid_q <= valid_i;
      if (valid_i) begin
        result_q <= result_d;
      end
    end
  end

  assign valid_o = valid_q;
  assign result_o = result_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_CORR_BYPASS: assert property (valid_i && !corr_en_i |=>
      valid_o && result_o == $past(raw_i))
    else $error("raw result altered with compensation off");
  AST_CORR_UNITY: assert property (valid_i && corr_en_i && gain_i == 12'h800
      && offset_i == 12'h000 |=> result_o == $past(raw_i))
    else $error("unity gain factor did not keep the result");
  AST_CORR_GAIN: assert property (valid_i && corr_en_i && gain_i == 12'hC00
      && offset_i == 12'h000 && raw_i <= 12'h800
      |=> result_o == $past(raw_i) + ($past(raw_i) >> 1))
    else $error("gain of one and a half not applied");
  AST_CORR_OFFSET: assert property (valid_i && corr_en_i && gain_i == 12'h800
      && offset_i == 12'hFFF && raw_i < 12'hFFF
      |=> result_o == $past(raw_i) + 12'h001)
    else $error("negative offset not subtracted as signed");

  COV_CORR_ON: cover property (valid_i && corr_en_i ##1 valid_o);
  COV_CORR_OFF: cover property (valid_i && !corr_en_i ##1 valid_o);
endmodule

// File: rtl/arcc_window.sv
// Purpose: window monitor upper threshold check on corrected results
// Assumes: result and upper limit are unsigned
// Notes: above flag holds until the next checked result or until the monitor is off
`timescale 1ns/1ns
module arcc_window (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // result in
  input wire logic valid_i,
  input wire logic [arcc_pkg::ARCC_RES_W-1:0] result_i,
  // monitor settings
  input wire logic win_en_i,
  input wire logic [arcc_pkg::ARCC_WIN_W-1:0] upper_i,
  // status out
  output logic above_o
);
  import arcc_pkg::*;

  logic above_q;
  logic above_now;

  // compare the result zero-extended to 16 bits against the upper limit
  assign above_now = {4'h0, result_i} > upper_i;

  // flag register
  always_ff @(posedge clk_i) begin
    if (rst_i || !win_en_i) begin
      above_q <= 1'b0;
    end else if (valid_i) begin
      above_q <= above_now;
    end
  end

  assign above_o = above_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_WIN_ABOVE: assert property (valid_i && win_en_i |=>
      above_o == ({4'h0, $past(result_i)} > $past(upper_i)))
    else $error("window upper check wrong");
  AST_WIN_OFF: assert property (!win_en_i |=> !above_o)
    else $error("above flag set while monitor off");

  COV_WIN_HIT: cover property (valid_i && win_en_i ##1 above_o);
endmodule

// File: rtl/arcc_top.sv
// Purpose: register tail of the converter: correction, window limit, trim, debug halt
// Assumes: classic Wishbone slave, 32-bit data, one clock, synchronous reset
// Notes: registers take one word each at index times four; unmapped reads give zero
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
module arcc_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // converter side
  input wire logic dbg_halt_i,
  input wire logic conv_valid_i,
  input wire logic [arcc_pkg::ARCC_RES_W-1:0] conv_data_i,
  output logic conv_run_o,
  output logic [arcc_pkg::ARCC_RES_W-1:0] result_o,
  output logic result_valid_o,
  output logic window_above_o,
  output logic [arcc_pkg::ARCC_TRIM_W-1:0] trim_o
);
  import arcc_pkg::*;

  logic ack_q;
  logic [31:0] rdata_q;
  logic [11:0] gain_q;
  logic [11:0] offs_q;
  logic [10:0] trim_q;
  logic run_q;
  logic [15:0] winup_q;
  logic [2:0] ctrl_q;
  logic req;
  logic wr_en;
  logic [5:0] idx;
  logic hit_gain;
  logic hit_offs;
  logic hit_trim;
  logic hit_dbg;
  logic hit_winup;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] cur_word;
  logic [31:0] new_word;
  logic [31:0] rdata_d;
  logic conv_en;
  logic corr_en;
  logic win_en;
  logic take_conv;
  logic corr_valid;
  logic [11:0] corr_result;

  // bus decode
  assign req = cyc_i && stb_i;
  assign idx = adr_i[7:2];
  assign wr_en = req && we_i && ack_q;
  assign hit_gain = idx == ARCC_IDX_GAIN;
  assign hit_offs = idx == ARCC_IDX_OFFS;
  assign hit_trim = idx == ARCC_IDX_TRIM;
  assign hit_dbg = idx == ARCC_IDX_DBG;
  assign hit_winup = idx == ARCC_IDX_WINUP;
  assign hit_ctrl = idx == ARCC_IDX_CTRL;
  assign hit_stat = idx == ARCC_IDX_STAT;

  // control bits
  assign conv_en = ctrl_q[ARCC_CTRL_EN_BIT];
  assign corr_en = ctrl_q[ARCC_CTRL_CORR_BIT];
  assign win_en = ctrl_q[ARCC_CTRL_WIN_BIT];

  // read mux, reserved bits read as zero
  assign rdata_d = hit_gain ? {20'h00000, gain_q} :
                   hit_offs ? {20'h00000, offs_q} :
                   hit_trim ? {21'h000000, trim_q} :
                   hit_dbg ? {31'h00000000, run_q} :
                   hit_winup ? {16'h0000, winup_q} :
                   hit_ctrl ? {29'h00000000, ctrl_q} :
                   hit_stat ? {14'h0000, conv_run_o, window_above_o, 4'h0, result_o} :
                   32'h00000000;
  assign cur_word = rdata_d;
  assign new_word = arcc_bytewrite(cur_word, dat_i, sel_i);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // correction, trim and window upper limit registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_q <= ARCC_GAIN_RST;
      offs_q <= ARCC_OFFS_RST;
      trim_q <= ARCC_TRIM_RST;
      winup_q <= ARCC_WINUP_RST;
    end else if (wr_en) begin
      if (hit_gain) begin
        gain_q <= new_word[11:0];
      end
      if (hit_offs) begin
        offs_q <= new_word[11:0];
      end
      if (hit_trim) begin
        trim_q <= new_word[10:0];
      end
      if (hit_winup) begin
        winup_q <= new_word[15:0];
      end
    end
  end

  // control and debug bits; run-while-halted locked while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= ARCC_CTRL_RST;
      run_q <= ARCC_DBG_RUN_RST;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_q <= new_word[2:0];
      end
      if (hit_dbg && !conv_en) begin
        run_q <= new_word[ARCC_DBG_RUN_BIT];
      end
    end
  end

  // converter runs while enabled unless halted by debug without run-while-halted
  assign conv_run_o = conv_en && (!dbg_halt_i || run_q);
  assign take_conv = conv_valid_i && conv_run_o;

  arcc_correct u_correct (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .valid_i(take_conv),
    .raw_i(conv_data_i),
    .corr_en_i(corr_en),
    .gain_i(gain_q),
    .offset_i(offs_q),
    .valid_o(corr_valid),
    .result_o(corr_result)
  );

  arcc_window u_window (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .valid_i(corr_valid),
    .result_i(corr_result),
    .win_en_i(win_en),
    .upper_i(winup_q),
    .above_o(window_above_o)
  );

  // outputs
  assign dat_o = rdata_q;
  assign ack_o = ack_q;
  assign result_o = corr_result;
  assign result_valid_o = corr_valid;
  assign trim_o = trim_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RUN_HALT: assert property (dbg_halt_i && !run_q |-> !conv_run_o)
    else $error("converter runs during debug halt");
  AST_RUN_FREE: assert property (conv_en && dbg_halt_i && run_q |-> conv_run_o)
    else $error("converter stopped with run-while-halted set");
  AST_HALT_NO_RESULT: assert property (conv_en && dbg_halt_i && !run_q
      |=> !result_valid_o)
    else $error("result produced during debug halt");
  AST_DBG_LOCK: assert property (conv_en && $past(conv_en) |-> $stable(run_q))
    else $error("run-while-halted changed while enabled");
  AST_DBG_WRITE: assert property (wr_en && hit_dbg && !conv_en && sel_i[0]
      |=> run_q == $past(dat_i[0]))
    else $error("run-while-halted write lost while disabled");

  // full writes land at the edge where ack is sampled high
  AST_GAIN_WRITE: assert property (
      wr_en && hit_gain && sel_i[1:0] == 2'h3
      |=> gain_q == $past(dat_i[11:0]))
    else $error("gain factor write lost");
  AST_OFFS_WRITE: assert property (
      wr_en && hit_offs && sel_i[1:0] == 2'h3
      |=> offs_q == $past(dat_i[11:0]))
    else $error("offset term write lost");
  AST_TRIM_WRITE: assert property (
      wr_en && hit_trim && sel_i[1:0] == 2'h3
      |=> trim_o == $past(dat_i[10:0]))
    else $error("trim write lost");
  AST_WINUP_WRITE: assert property (
      wr_en && hit_winup && sel_i[1:0] == 2'h3
      |=> winup_q == $past(dat_i[15:0]))
    else $error("upper limit write lost");
  AST_CTRL_WRITE: assert property (
      wr_en && hit_ctrl && sel_i[0]
      |=> ctrl_q == $past(dat_i[2:0]))
    else $error("control write lost");

  // a byte lane left unselected keeps its old contents
  AST_GAIN_LANE: assert property (
      wr_en && hit_gain && sel_i[1:0] == 2'h1
      |=> gain_q[11:8] == $past(gain_q[11:8]))
    else $error("unselected gain lane changed");
  AST_WINUP_LANE: assert property (
      wr_en && hit_winup && sel_i[1:0] == 2'h1
      |=> winup_q[15:8] == $past(winup_q[15:8]))
    else $error("unselected upper limit lane changed");

  // registers change only when written
  AST_GAIN_HOLD: assert property (
      !(wr_en && hit_gain)
      |=> $stable(gain_q))
    else $error("gain factor changed without a write");
  AST_OFFS_HOLD: assert property (
      !(wr_en && hit_offs)
      |=> $stable(offs_q))
    else $error("offset term changed without a write");
  AST_TRIM_HOLD: assert property (
      !(wr_en && hit_trim)
      |=> $stable(trim_o))
    else $error("trim changed without a write");
  AST_WINUP_HOLD: assert property (
      !(wr_en && hit_winup)
      |=> $stable(winup_q))
    else $error("upper limit changed without a write");
  AST_CTRL_HOLD: assert property (
      !(wr_en && hit_ctrl)
      |=> $stable(ctrl_q))
    else $error("control changed without a write");

  // read data are taken at the request edge and shown with ack
  AST_GAIN_READ: assert property (
      req && !ack_q && hit_gain
      |=> dat_o == {20'h00000, $past(gain_q)})
    else $error("gain factor read wrong");
  AST_OFFS_READ: assert property (
      req && !ack_q && hit_offs
      |=> dat_o == {20'h00000, $past(offs_q)})
    else $error("offset term read wrong");
  AST_TRIM_READ: assert property (
      req && !ack_q && hit_trim
      |=> dat_o == {21'h000000, $past(trim_q)})
    else $error("trim read wrong");
  AST_WINUP_READ: assert property (
      req && !ack_q && hit_winup
      |=> dat_o == {16'h0000, $past(winup_q)})
    else $error("upper limit read wrong");
  AST_DBG_READ: assert property (
      req && !ack_q && hit_dbg
      |=> dat_o == {31'h00000000, $past(run_q)})
    else $error("debug control read wrong");
  AST_CTRL_READ: assert property (
      req && !ack_q && hit_ctrl
      |=> dat_o == {29'h00000000, $past(ctrl_q)})
    else $error("control read wrong");
  AST_STAT_READ: assert property (
      req && !ack_q && hit_stat
      |=> dat_o == {14'h0000, $past(conv_run_o), $past(window_above_o), 4'h0, $past(result_o)})
    else $error("status read wrong");

  // results are taken only while the converter runs
  AST_RUN_NEEDS_EN: assert property (
      !conv_en
      |-> !conv_run_o)
    else $error("converter runs while disabled");
  AST_STOPPED_NO_RESULT: assert property (
      !conv_run_o
      |=> !result_valid_o)
    else $error("result stored while converter stopped");
  AST_RESULT_TAKEN: assert property (
      conv_valid_i && conv_run_o
      |=> result_valid_o)
    else $error("result dropped while converter runs");
  AST_DBG_WRITE_LOCKED: assert property (
      wr_en && hit_dbg && conv_en
      |=> $stable(run_q))
    else $error("run-while-halted written while enabled");
  AST_OFF_STORES_RAW: assert property (
      conv_valid_i && conv_run_o && !corr_en
      |=> result_o == $past(conv_data_i))
    else $error("result altered with compensation off");

  COV_BUS_WRITE: cover property (wr_en && hit_gain);
  COV_HALT_RUN: cover property (dbg_halt_i && conv_run_o);
endmodule

// File: dv/arcc_top_bench.sv
// Purpose: self-checking bench for the converter result correction register block
// Assumes: wishbone ack one cycle after a request is taken, results one cycle after taken
// Notes: the checker assertions sit in the design files, so the bench only drives and compares
`timescale 1ns/1ns
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); \
  end \
end

module arcc_top_bench;
  import arcc_pkg::*;
  // register byte addresses
  localparam logic [7:0] A_GAIN = {ARCC_IDX_GAIN, 2'b00};
  localparam logic [7:0] A_OFFS = {ARCC_IDX_OFFS, 2'b00};
  localparam logic [7:0] A_TRIM = {ARCC_IDX_TRIM, 2'b00};
  localparam logic [7:0] A_DBG = {ARCC_IDX_DBG, 2'b00};
  localparam logic [7:0] A_WINUP = {ARCC_IDX_WINUP, 2'b00};
  localparam logic [7:0] A_CTRL = {ARCC_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {ARCC_IDX_STAT, 2'b00};
  localparam logic [7:0] A_NONE = 8'hFC;
  // design inputs, all given a value at time zero
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic dbg_halt_i = 1'b0;
  logic conv_valid_i = 1'b0;
  logic [ARCC_RES_W-1:0] conv_data_i = 12'h000;
  // design outputs
  logic [31:0] dat_o;
  logic ack_o;
  logic conv_run_o;
  logic [ARCC_RES_W-1:0] result_o;
  logic result_valid_o;
  logic window_above_o;
  logic [ARCC_TRIM_W-1:0] trim_o;
  int err_total = 0;
  int compares = 0;

  always #2 clk_i = ~clk_i;

  arcc_top i_arcc_top (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .dbg_halt_i(dbg_halt_i), .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i),
    .conv_run_o(conv_run_o), .result_o(result_o), .result_valid_o(result_valid_o),
    .window_above_o(window_above_o), .trim_o(trim_o)
  );

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one classic cycle; request held until ack is sampled high, then idle one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, 4'hF, q);
    `CHK(q, exp)
  endtask

  // one raw result; checks its strobe, value and the window flag a cycle later
  task automatic conv(input logic [11:0] raw, input logic take, input logic [11:0] exp,
                      input logic above);
    conv_valid_i <= 1'b1;
    conv_data_i <= raw;
    @(posedge clk_i);
    conv_valid_i <= 1'b0;
    #1;
    `CHK(result_valid_o, take)
    if (take) begin
      `CHK(result_o, exp)
    end
    @(posedge clk_i);
    #1;
    `CHK(window_above_o, above)
    @(posedge clk_i);
  endtask

  task automatic test_reset();
    rd(A_GAIN, 32'h00000000);
    rd(A_OFFS, 32'h00000000);
    rd(A_TRIM, 32'h00000000);
    rd(A_DBG, 32'h00000000);
    rd(A_WINUP, 32'h00000000);
    rd(A_CTRL, 32'h00000000);
    `CHK(trim_o, 11'h000)
    $display("test reset values done");
  endtask

  task automatic test_regs();
    logic [31:0] q;
    wr(A_GAIN, 32'hFFFFFFFF);
    rd(A_GAIN, 32'h00000FFF);
    wr(A_OFFS, 32'hFFFFFFFF);
    rd(A_OFFS, 32'h00000FFF);
    wr(A_TRIM, 32'hFFFFFFFF);
    rd(A_TRIM, 32'h000007FF);
    wb(1'b1, A_TRIM, 32'h0000003C, 4'h1, q);
    rd(A_TRIM, 32'h0000073C);
    `CHK(trim_o, 11'h73C)
    wr(A_WINUP, 32'h0001ABCD);
    rd(A_WINUP, 32'h0000ABCD);
    wr(A_NONE, 32'hFFFFFFFF);
    rd(A_NONE, 32'h00000000);
    $display("test register access done");
  endtask

  task automatic test_correction();
    wr(A_GAIN, 32'h00000400);
    wr(A_OFFS, 32'h00000010);
    wr(A_WINUP, 32'h0000FFFF);
    wr(A_CTRL, 32'h00000001);
    conv(12'h123, 1'b1, 12'h123, 1'b0);
    wr(A_CTRL, 32'h00000003);
    rd(A_CTRL, 32'h00000003);
    conv(12'h210, 1'b1, 12'h100, 1'b0);
    wr(A_GAIN, 32'h00000FFF);
    wr(A_OFFS, 32'h00000000);
    conv(12'h400, 1'b1, 12'h7FF, 1'b0);
    wr(A_GAIN, 32'h00000800);
    wr(A_OFFS, 32'h00000FF0);
    conv(12'h100, 1'b1, 12'h110, 1'b0);
    conv(12'hFFF, 1'b1, 12'hFFF, 1'b0);
    wr(A_OFFS, 32'h00000010);
    conv(12'h005, 1'b1, 12'h000, 1'b0);
    wr(A_GAIN, 32'h00000C00);
    wr(A_OFFS, 32'h00000000);
    conv(12'h200, 1'b1, 12'h300, 1'b0);
    wr(A_GAIN, 32'h00000800);
    conv(12'h5A5, 1'b1, 12'h5A5, 1'b0);
    wr(A_OFFS, 32'h00000FFF);
    conv(12'h100, 1'b1, 12'h101, 1'b0);
    $display("test correction done");
  endtask

  task automatic test_window();
    wr(A_OFFS, 32'h00000000);
    wr(A_WINUP, 32'h00000100);
    wr(A_CTRL, 32'h00000005);
    conv(12'h101, 1'b1, 12'h101, 1'b1);
    conv(12'h100, 1'b1, 12'h100, 1'b0);
    conv(12'h1FF, 1'b1, 12'h1FF, 1'b1);
    rd(A_STAT, 32'h000301FF);
    wr(A_CTRL, 32'h00000001);
    #1;
    `CHK(window_above_o, 1'b0)
    @(posedge clk_i);
    $display("test window monitor done");
  endtask

  task automatic test_debug();
    dbg_halt_i <= 1'b1;
    @(posedge clk_i);
    #1;
    `CHK(conv_run_o, 1'b0)
    @(posedge clk_i);
    conv(12'h222, 1'b0, 12'h000, 1'b0);
    wr(A_DBG, 32'h00000001);
    rd(A_DBG, 32'h00000000);
    wr(A_CTRL, 32'h00000000);
    wr(A_DBG, 32'h00000001);
    rd(A_DBG, 32'h00000001);
    wr(A_CTRL, 32'h00000001);
    #1;
    `CHK(conv_run_o, 1'b1)
    @(posedge clk_i);
    conv(12'h333, 1'b1, 12'h333, 1'b0);
    dbg_halt_i <= 1'b0;
    @(posedge clk_i);
    $display("test debug halt done");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    test_regs();
    test_correction();
    test_window();
    test_debug();
    report_and_stop();
  end
endmodule
